// [irf_top.sv]
`timescale 1ns/1ps
// Interrupt request flag registers with a Wishbone register port.
module irf_top
  import irf_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Peripheral events, one-cycle pulses.
  input  wire logic        sleep_exec_i,
  input  wire logic        direct_trans_i,
  input  wire logic        direct_transition_on_i,
  input  wire logic        conv_done_i,
  input  wire logic        timer_hi_match_i,
  input  wire logic        timer_hi_ovf_i,
  input  wire logic        timer_lo_match_i,
  input  wire logic        timer_lo_ovf_i,
  input  wire logic        event_ctr_ovf_i,
  // Wakeup pins, already edge-selected.
  input  wire logic [7:0]  wakeup_pin_irq_mode_i,
  input  wire logic [7:0]  wakeup_pin_edge_i,
  // Flags and interrupt.
  output logic      [7:0]  periph_flag_o,
  output logic      [7:0]  wakeup_flag_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // Decode.
  // ---------------------------------------------------------------
  logic [7:0] enable_reg;
  logic [7:0] wake_en_reg;
  logic [7:0] periph_flags;
  logic [7:0] wake_flags;
  logic [7:0] rd_word;
  logic [7:0] rd_data;
  logic       wr_pulse;

  wire sel_periph = (wb_adr_i == IRF_PERIPH_REQ_OFF);
  wire sel_wake   = (wb_adr_i == IRF_WAKEUP_REQ_OFF);
  wire sel_en     = (wb_adr_i == IRF_ENABLE_OFF);
  wire sel_wen    = (wb_adr_i == IRF_WAKE_EN_OFF);
  wire wr_periph  = wr_pulse & sel_periph;
  wire wr_wake    = wr_pulse & sel_wake;

  // ---------------------------------------------------------------
  // Peripheral set events.
  // ---------------------------------------------------------------
  logic [7:0] periph_set;
  assign periph_set[IRF_BIT_TRANS] =
    sleep_exec_i & direct_trans_i & direct_transition_on_i;
  assign periph_set[IRF_BIT_CONV] = conv_done_i;
  assign periph_set[5] = 1'b0;
  assign periph_set[4] = 1'b0;
  assign periph_set[IRF_BIT_TIMER_HI] =
    timer_hi_match_i | timer_hi_ovf_i;
  assign periph_set[IRF_BIT_TIMER_LO] =
    timer_lo_match_i | timer_lo_ovf_i;
  assign periph_set[1] = 1'b0;
  assign periph_set[IRF_BIT_EVT] = event_ctr_ovf_i;

  // Wakeup flag sets only for pins configured as interrupt inputs.
  wire [7:0] wake_set =
    wakeup_pin_irq_mode_i & wakeup_pin_edge_i;

  // ---------------------------------------------------------------
  // Flag storage.
  // ---------------------------------------------------------------
  // Data ones never set a flag; only zeros clear.
  irf_flag_bits u_periph (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .set_i      (periph_set),
    .clr_we_i   (wr_periph),
    .clr_data_i (wb_dat_i[7:0]),
    .flag_o     (periph_flags)
  );

  irf_flag_bits u_wake (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .set_i      (wake_set),
    .clr_we_i   (wr_wake),
    .clr_data_i (wb_dat_i[7:0]),
    .flag_o     (wake_flags)
  );

  // ---------------------------------------------------------------
  // Enable registers.
  // ---------------------------------------------------------------
  // Reserved enable bits 4 and 1 are kept at one as software sees them.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable_reg  <= IRF_ENABLE_RESET;
      wake_en_reg <= IRF_FLAGS_RESET;
    end
    else
    begin
      if (wr_pulse & sel_en)
        enable_reg <= wb_dat_i[7:0] | IRF_PERIPH_ONES;
      if (wr_pulse & sel_wen)
        wake_en_reg <= wb_dat_i[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Read mux.
  // ---------------------------------------------------------------
  // Bit 5 reads zero, bits 4 and 1 read one.
  wire [7:0] periph_view =
    (periph_flags & IRF_PERIPH_FLAGS) | IRF_PERIPH_ONES;

  assign rd_word = sel_periph ? periph_view :
                   sel_wake   ? wake_flags  :
                   sel_en     ? enable_reg  :
                   sel_wen    ? wake_en_reg : 8'h00;

  irf_wb_slave u_bus (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .cyc_i      (wb_cyc_i),
    .stb_i      (wb_stb_i),
    .we_i       (wb_we_i),
    .sel_i      (wb_sel_i),
    .rd_word_i  (rd_word),
    .ack_o      (wb_ack_o),
    .rd_data_o  (rd_data),
    .wr_pulse_o (wr_pulse)
  );

  assign wb_dat_o = {24'h000000, rd_data};

  // ---------------------------------------------------------------
  // Interrupt output.
  // ---------------------------------------------------------------
  // Enables only gate the request; the flags stay visible regardless.
  wire [7:0] periph_pend =
    periph_flags & enable_reg & IRF_PERIPH_FLAGS;
  assign irq_o = (|periph_pend) | (|(wake_flags & wake_en_reg));

  assign periph_flag_o = periph_flags & IRF_PERIPH_FLAGS;
  assign wakeup_flag_o = wake_flags;

endmodule : irf_top

// [irf_pkg.sv]
// Overview of operation
// - Sleep with direct transition enabled sets the transition flag, bit 7.
// - Each finished analog conversion sets the conversion flag, bit 6.
// - Upper timer half compare match or overflow sets bit 3.
// - Lower timer half compare match or overflow sets bit 2.
// - Event counter overflow sets the event counter flag, bit 0.
// - Software writes clear peripheral flags with 0; writing 1 leaves them.
// - Peripheral request bit 5 is read-only and reads as zero.
// - Peripheral request bits 4 and 1 always read as one.
// - Wakeup flag sets when its pin is an interrupt input and edge seen.
// - Writing 0 clears a wakeup flag; otherwise it stays set.
// - Transition flag requests interrupt only while its enable bit is 1.
package irf_pkg;

  // ---------------------------------------------------------------
  // Register map, word offsets in bytes.
  // ---------------------------------------------------------------
  localparam logic [3:0] IRF_PERIPH_REQ_OFF = 4'h0;
  localparam logic [3:0] IRF_WAKEUP_REQ_OFF = 4'h4;
  localparam logic [3:0] IRF_ENABLE_OFF     = 4'h8;
  localparam logic [3:0] IRF_WAKE_EN_OFF    = 4'hc;

  // ---------------------------------------------------------------
  // Field positions and fixed values.
  // ---------------------------------------------------------------
  localparam int         IRF_BIT_TRANS    = 7;
  localparam int         IRF_BIT_CONV     = 6;
  localparam int         IRF_BIT_TIMER_HI = 3;
  localparam int         IRF_BIT_TIMER_LO = 2;
  localparam int         IRF_BIT_EVT      = 0;
  localparam logic [7:0] IRF_PERIPH_FLAGS = 8'hcd;
  localparam logic [7:0] IRF_PERIPH_ONES  = 8'h12;
  localparam logic [7:0] IRF_FLAGS_RESET  = 8'h00;
  localparam logic [7:0] IRF_ENABLE_RESET = 8'h12;

endpackage : irf_pkg

// [irf_flag_bits.sv]
`timescale 1ns/1ps
// Eight sticky flags: set by hardware, cleared by writing zero.
module irf_flag_bits
  import irf_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Set events and clear strobe.
  input  wire logic [7:0] set_i,
  input  wire logic       clr_we_i,
  input  wire logic [7:0] clr_data_i,
  // Flag state.
  output logic      [7:0] flag_o
);

  // ---------------------------------------------------------------
  // Per-bit flag storage.
  // ---------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_bit
      logic flag_reg;
      wire  clr_hit = clr_we_i & ~clr_data_i[b];
      // The set term is applied last so an event is never lost to a clear.
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          flag_reg <= IRF_FLAGS_RESET[b];
        else
          flag_reg <= set_i[b] | (flag_reg & ~clr_hit);
      end
      assign flag_o[b] = flag_reg;
    end
  endgenerate

endmodule : irf_flag_bits

// [irf_wb_slave.sv]
`timescale 1ns/1ps
// Classic Wishbone handshake: one-cycle ack, registered read data.
module irf_wb_slave
  import irf_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Wishbone request side.
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [3:0] sel_i,
  // Read data to present.
  input  wire logic [7:0] rd_word_i,
  // Answer.
  output logic            ack_o,
  output logic      [7:0] rd_data_o,
  output logic            wr_pulse_o
);

  logic ack_reg;
  logic [7:0] rd_reg;

  // ---------------------------------------------------------------
  // Handshake.
  // ---------------------------------------------------------------
  wire req = cyc_i & stb_i & ~ack_reg;

  // Ack falls in the cycle after it rose, so each access acts once.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rd_reg  <= 8'h00;
    end
    else
    begin
      ack_reg <= req;
      if (req & ~we_i)
        rd_reg <= rd_word_i;
    end
  end

  assign ack_o      = ack_reg;
  assign rd_data_o  = rd_reg;
  assign wr_pulse_o = req & we_i & sel_i[0];

endmodule : irf_wb_slave

// [irf_checker.sv]
`timescale 1ns/1ps
// Ties each flag output to the input event or bus write behind it.
module irf_checker
  import irf_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Causes.
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic [3:0]  wb_adr_i,
  input wire logic        sleep_exec_i,
  input wire logic        direct_trans_i,
  input wire logic        direct_transition_on_i,
  input wire logic        conv_done_i,
  input wire logic        timer_hi_match_i,
  input wire logic        timer_hi_ovf_i,
  input wire logic        timer_lo_match_i,
  input wire logic        timer_lo_ovf_i,
  input wire logic        event_ctr_ovf_i,
  input wire logic [7:0]  wakeup_pin_irq_mode_i,
  input wire logic [7:0]  wakeup_pin_edge_i,
  // Effects.
  input wire logic [31:0] wb_dat_o,
  input wire logic [7:0]  periph_flag_o,
  input wire logic [7:0]  wakeup_flag_o,
  input wire logic        irq_o
);
  logic [7:0] wk_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Wakeup causes one edge back; cleared in reset so none goes stale.
  always_ff @(posedge clk_i)
    if (rst_i) wk_reg <= 8'h00;
    else wk_reg <= wakeup_pin_irq_mode_i & wakeup_pin_edge_i;
  // Events set their flag next edge, even against a clearing write.
  a_trans_set: assert property (
    sleep_exec_i && direct_trans_i && direct_transition_on_i
    |=> periph_flag_o[7]) else $error("transition flag missed");
  a_conv_set: assert property (
    conv_done_i |=> periph_flag_o[6]) else $error("conv flag missed");
  a_timer_hi_set: assert property (
    timer_hi_match_i || timer_hi_ovf_i |=> periph_flag_o[3])
    else $error("timer hi flag missed");
  a_timer_lo_set: assert property (
    timer_lo_match_i || timer_lo_ovf_i |=> periph_flag_o[2])
    else $error("timer lo flag missed");
  a_event_set: assert property (
    event_ctr_ovf_i |=> periph_flag_o[0]) else $error("event flag missed");
  a_wake_set: assert property (
    (wakeup_flag_o & wk_reg) == wk_reg) else $error("wakeup flag missed");
  // A flag may only fall at the answer to a write.
  a_periph_clear: assert property (
    |($past(periph_flag_o) & ~periph_flag_o) |-> wb_ack_o && wb_we_i)
    else $error("flag fell without write");
  a_wake_clear: assert property (
    |($past(wakeup_flag_o) & ~wakeup_flag_o) |-> wb_ack_o && wb_we_i)
    else $error("wakeup fell without write");
  // Reserved bits are judged on the read data software really sees.
  a_rsvd_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == IRF_PERIPH_REQ_OFF
    |-> wb_dat_o[5] == 1'b0) else $error("reserved bit set");
  a_rsvd_ones: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == IRF_PERIPH_REQ_OFF
    |-> wb_dat_o[4] && wb_dat_o[1]) else $error("reserved ones missing");
  a_irq_quiet: assert property (
    periph_flag_o == 8'h00 && wakeup_flag_o == 8'h00 |-> !irq_o)
    else $error("irq without flag");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_irq: cover property (irq_o);
  c_race: cover property (conv_done_i && wb_we_i);
endmodule : irf_checker

bind irf_top irf_checker chk_u (.*);

// [irf_host.sv]
`timescale 1ns/1ps
// Software side: classic single Wishbone cycles, one at a time.
module irf_host
  import irf_pkg::*;
(
  // Clock and answer.
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rd_i,
  // Request.
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [3:0]  adr_o,
  output logic      [31:0] dat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, dat_o} = '0;
  // Held until ack; then lines flip so no stale address is trusted.
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output bit ok);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 40);
    ok = (ack_i === 1'b1);
    q = rd_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~adr_o;
    dat_o <= ~dat_o;
  endtask : xfer
endmodule : irf_host

// [test_irq_request_flag_regs.sv]
`timescale 1ns/1ps
// Random flag traffic against a software model of both registers.
module test_irq_request_flag_regs;
  import irf_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat;
  logic [8:0]  ev;
  logic [7:0]  mode, edg, pfl, wfl, pf, wf, q, d;
  int          fail_count, checks_done;
  bit          ok;
  irf_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sleep_exec_i(ev[8]), .direct_trans_i(ev[7]),
    .direct_transition_on_i(ev[6]), .conv_done_i(ev[5]),
    .timer_hi_match_i(ev[4]), .timer_hi_ovf_i(ev[3]),
    .timer_lo_match_i(ev[2]), .timer_lo_ovf_i(ev[1]),
    .event_ctr_ovf_i(ev[0]), .wakeup_pin_irq_mode_i(mode),
    .wakeup_pin_edge_i(edg), .periph_flag_o(pfl), .wakeup_flag_o(wfl),
    .irq_o(irq));
  irf_host host_u (.clk_i(clk_i), .ack_i(ack), .rd_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wdat));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Flags that one event word must set; sleep needs all three high.
  function automatic logic [7:0] set_of(input logic [8:0] e);
    return {&e[8:6], e[5], 2'b00, |e[4:3], |e[2:1], 1'b0, e[0]};
  endfunction : set_of
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
    host_u.xfer(w, a, v, q, ok);
    if (!ok)
    begin
      fail_count++;
      close_out();
    end
  endtask : acc
  // One event cycle, then idle; flags are looked at once settled.
  task automatic pulse(input logic [8:0] e, input logic [7:0] m, g);
    @(posedge clk_i);
    ev <= e;
    mode <= m;
    edg <= g;
    @(posedge clk_i);
    ev <= 9'h000;
    edg <= 8'h00;
    pf |= set_of(e);
    wf |= m & g;
    #1;
    chk(pfl, pf);
    chk(wfl, wf);
  endtask : pulse
  initial
  begin
    {ev, mode, edg, pf, wf} = '0;
    rst_i = 1'b1;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(77));
    // The second pass is a reset in mid-run with flags set.
    for (int r = 0; r < 2; r++)
    begin
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      pf = 8'h00;
      wf = 8'h00;
      acc(0, IRF_PERIPH_REQ_OFF, 8'h00);
      chk(q, IRF_PERIPH_ONES);
      acc(0, IRF_ENABLE_OFF, 8'h00);
      chk(q, IRF_ENABLE_RESET);
      acc(0, 4'h2, 8'h00);
      chk(q, 8'h00);
      repeat (40)
      begin
        pulse(9'($urandom), 8'($urandom), 8'($urandom));
        d = 8'($urandom);
        acc(1, IRF_PERIPH_REQ_OFF, d);
        pf &= d;
        acc(0, IRF_PERIPH_REQ_OFF, 8'h00);
        chk(q, pf | IRF_PERIPH_ONES);
        d = 8'($urandom);
        acc(1, IRF_WAKEUP_REQ_OFF, d);
        wf &= d;
        acc(0, IRF_WAKEUP_REQ_OFF, 8'h00);
        chk(q, wf);
        chk(8'(irq), 8'h00);
      end
    end
    // Every flag set in the very cycle a zero write lands.
    fork
      acc(1, IRF_PERIPH_REQ_OFF, 8'h00);
      pulse(9'h1ff, 8'hff, 8'hff);
    join
    acc(0, IRF_PERIPH_REQ_OFF, 8'h00);
    chk(q, 8'hdf);
    acc(1, IRF_ENABLE_OFF, 8'h80);
    chk(8'(irq), 8'h01);
    acc(1, IRF_PERIPH_REQ_OFF, 8'h7f);
    chk(8'(irq), 8'h00);
    acc(1, IRF_WAKE_EN_OFF, 8'h01);
    chk(8'(irq), 8'h01);
    acc(1, IRF_WAKEUP_REQ_OFF, 8'hfe);
    chk(8'(irq), 8'h00);
    close_out();
  end
endmodule : test_irq_request_flag_regs
